//--- common/imc_pkg.sv
// package: register map, command codes and carriers of the command block
package imc_pkg;
   // ==================================================
   // register offsets
   localparam int ADDR_W = 7;
   localparam logic [6:0] OFS_CMD = 7'h0a;
   localparam logic [6:0] OFS_PARAM0 = 7'h0b;
   localparam logic [6:0] OFS_STATUS = 7'h20;
   localparam logic [6:0] OFS_SENS_CTRL = 7'h21;
   localparam logic [6:0] OFS_FEAT_CTRL = 7'h22;
   localparam logic [6:0] OFS_ID0 = 7'h30;
   localparam logic [6:0] OFS_RST_STAT = 7'h4d;
   localparam logic [6:0] OFS_TAP = 7'h59;
   localparam logic [6:0] OFS_STEP_LOW = 7'h5a;
   localparam logic [6:0] OFS_STEP_MID = 7'h5b;
   localparam logic [6:0] OFS_STEP_HIGH = 7'h5c;
   localparam logic [6:0] OFS_SOFT_RST = 7'h60;
   localparam int N_PARAM = 8;
   localparam int N_ID = 9;
   localparam int FW_W = 24;
   localparam int UID_W = 48;
   // ==================================================
   // field positions and values
   localparam int DONE_BIT = 7;
   localparam int INT_EN_BIT = 3;
   localparam int INT_DIS_BIT = 7;
   localparam int TAP_DIR_BIT = 7;
   localparam int TAP_AXIS_LSB = 4;
   localparam int TAP_NUM_LSB = 0;
   localparam logic [1:0] TAP_NUM_BAD = 2'h3;
   localparam int PULLUP_W = 4;
   localparam logic [7:0] RST_MAGIC = 8'hb0;
   localparam logic [7:0] RST_DONE_VAL = 8'h80;
   localparam logic [7:0] CTRL_RST_VAL = 8'h00;
   localparam logic [23:0] STEP_RST_VAL = 24'h000000;
   // ==================================================
   // command codes
   localparam logic [7:0] CODE_ACK = 8'h00;
   localparam logic [7:0] CODE_FIFO_RST = 8'h04;
   localparam logic [7:0] CODE_FIFO_REQ = 8'h05;
   localparam logic [7:0] CODE_WOM = 8'h08;
   localparam logic [7:0] CODE_ACC_OFS = 8'h09;
   localparam logic [7:0] CODE_GYR_OFS = 8'h0a;
   localparam logic [7:0] CODE_TAP_CFG = 8'h0c;
   localparam logic [7:0] CODE_PED_CFG = 8'h0d;
   localparam logic [7:0] CODE_MOT_CFG = 8'h0e;
   localparam logic [7:0] CODE_STEP_RST = 8'h0f;
   localparam logic [7:0] CODE_COPY_ID = 8'h10;
   localparam logic [7:0] CODE_PULLUP = 8'h11;
   localparam logic [7:0] CODE_CLK_GATE = 8'h12;
   localparam logic [7:0] CODE_GYR_CAL = 8'ha2;
   localparam logic [7:0] CODE_GAIN_RST = 8'haa;
   // strobe indices, one per function
   localparam int N_CMD = 14;
   localparam int IDX_W = 4;
   localparam logic [3:0] CMD_FIFO_RST = 4'h0;
   localparam logic [3:0] CMD_FIFO_REQ = 4'h1;
   localparam logic [3:0] CMD_WOM = 4'h2;
   localparam logic [3:0] CMD_ACC_OFS = 4'h3;
   localparam logic [3:0] CMD_GYR_OFS = 4'h4;
   localparam logic [3:0] CMD_TAP_CFG = 4'h5;
   localparam logic [3:0] CMD_PED_CFG = 4'h6;
   localparam logic [3:0] CMD_MOT_CFG = 4'h7;
   localparam logic [3:0] CMD_STEP_RST = 4'h8;
   localparam logic [3:0] CMD_COPY_ID = 4'h9;
   localparam logic [3:0] CMD_PULLUP = 4'ha;
   localparam logic [3:0] CMD_CLK_GATE = 4'hb;
   localparam logic [3:0] CMD_GYR_CAL = 4'hc;
   localparam logic [3:0] CMD_GAIN_RST = 4'hd;
   // ==================================================
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int EXEC_TIME_NS = 200;
   localparam int EXEC_CYCLES =
      (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==================================================
   // types
   typedef enum logic [1:0] {PROT_PLAIN, PROT_READ, PROT_WRITE} imc_prot_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } imc_reg_req_t;
   typedef struct packed {
      logic valid;
      logic negative;
      logic [1:0] axis;
      logic [1:0] count;
   } imc_tap_t;
endpackage

//--- hw/imc_cmd_exec.sv
// command decoder and executor: classifies codes and times each function
`timescale 1ns/1ps
module imc_cmd_exec import imc_pkg::*; #(
   parameter int EXEC_LEN = EXEC_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic [7:0] code_i,
   output logic known_o,
   output imc_prot_t prot_o,
   output logic busy_o,
   output logic done_o,
   output logic [N_CMD-1:0] stb_o
);
   localparam int CNT_W = $clog2(EXEC_LEN + 1);
   typedef enum logic {ST_IDLE, ST_RUN} imc_exec_st_t;

   imc_exec_st_t st_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [IDX_W-1:0] idx_ff;
   logic [IDX_W-1:0] idx;
   logic last;

   // refuse a run length the counter cannot serve
   if (EXEC_LEN < 1) begin : g_bad_len
      $error("EXEC_LEN must be at least one cycle");
   end

   // ==================================================
   // code table: function index and protocol type
   always_comb begin
      known_o = 1'b1;
      idx = CMD_FIFO_RST;
      prot_o = PROT_WRITE;
      unique case (code_i)
         CODE_FIFO_RST: prot_o = PROT_PLAIN;
         CODE_FIFO_REQ: begin
            idx = CMD_FIFO_REQ;
            prot_o = PROT_READ;
         end
         CODE_WOM: idx = CMD_WOM;
         CODE_ACC_OFS: idx = CMD_ACC_OFS;
         CODE_GYR_OFS: idx = CMD_GYR_OFS;
         CODE_TAP_CFG: idx = CMD_TAP_CFG;
         CODE_PED_CFG: idx = CMD_PED_CFG;
         CODE_MOT_CFG: idx = CMD_MOT_CFG;
         CODE_STEP_RST: idx = CMD_STEP_RST;
         CODE_COPY_ID: begin
            idx = CMD_COPY_ID;
            prot_o = PROT_READ;
         end
         CODE_PULLUP: idx = CMD_PULLUP;
         CODE_CLK_GATE: idx = CMD_CLK_GATE;
         CODE_GYR_CAL: idx = CMD_GYR_CAL;
         CODE_GAIN_RST: idx = CMD_GAIN_RST;
         default: begin
            known_o = 1'b0;
            prot_o = PROT_PLAIN;
         end
      endcase
   end

   assign busy_o = (st_ff == ST_RUN);
   assign last = (cnt_ff == CNT_W'(1));

   // ==================================================
   // run state: one function at a time, fixed length
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= ST_IDLE;
         cnt_ff <= '0;
         idx_ff <= '0;
      end else if (srst_i) begin
         st_ff <= ST_IDLE;
         cnt_ff <= '0;
      end else if (st_ff == ST_IDLE && start_i && known_o) begin
         st_ff <= ST_RUN;
         cnt_ff <= CNT_W'(EXEC_LEN);
         idx_ff <= idx;
      end else if (st_ff == ST_RUN) begin
         cnt_ff <= cnt_ff - CNT_W'(1);
         if (last) begin
            st_ff <= ST_IDLE;
         end
      end
   end

   // ==================================================
   // function strobe and completion pulse at the end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
         stb_o <= '0;
      end else begin
         done_o <= busy_o && last && !srst_i;
         stb_o <= '0;
         if (busy_o && last && !srst_i) begin
            stb_o[idx_ff] <= 1'b1;
         end
      end
   end
endmodule

//--- hw/imc_host_cmd.sv
// host command handshake, parameter, result and soft reset registers
`timescale 1ns/1ps
// Function
// - a written code matching the table runs its function
// - finishing sets status bit 7; line raises when enabled
// - acknowledge clears status bit 7 and drops the line
// - read-type results are ready once the handshake ends
// - plain-type codes move no data around the handshake
// - 0x04 is plain FIFO reset, 0x05 read-type FIFO request
// - 0x08, 0x09, 0x0A are write-type motion and offset codes
// - 0x0C to 0x0F are write-type tap, pedometer, motion, step
// - 0x10 copies ID and version; 0x11 pull-ups; 0x12 gating
// - 0xA2 gyro calibration, 0xAA gain restore, both write-type
// - eight byte parameter registers at 0x0B through 0x12
// - tap bit 7 gives direction, 1 for negative
// - tap bits 5:4 give axis, 0 none, 1 X, 2 Y, 3 Z
// - tap bits 1:0 give count, none, single, double
// - 24-bit step count in three bytes, reset to zero
// - writing 0xB0 to the reset register resets at once
// - register 0x4D reads 0x80 after any reset
// - command register sits on the common register port
// - FIFO reset clears data, count and flags
module imc_host_cmd import imc_pkg::*; #(
   parameter int EXEC_LEN = EXEC_CYCLES
) (
   input wire logic SYS_CLK_I,
   input wire logic NRST_I,
   input wire imc_reg_req_t REG_REQ_I,
   input wire imc_tap_t TAP_EVT_I,
   input wire logic STEP_INC_I,
   input wire logic [UID_W-1:0] UID_I,
   input wire logic [FW_W-1:0] FW_VER_I,
   output logic [7:0] REG_RDATA_O,
   output logic FIRST_IRQ_PIN_O,
   output logic [N_CMD-1:0] CMD_STB_O,
   output logic [8*N_PARAM-1:0] PARAM_O,
   output logic [PULLUP_W-1:0] PULLUP_DIS_O,
   output logic FIFO_RST_O,
   output logic SOFT_RST_O
);
   logic [7:0] cmd_ff;
   logic done_ff;
   logic int_ff;
   logic [7:0] sens_ctrl_ff;
   logic [7:0] feat_ctrl_ff;
   logic [7:0] param_ff [N_PARAM];
   logic [7:0] id_ff [N_ID];
   logic copy_pend_ff;
   logic [7:0] tap_ff;
   logic [23:0] step_ff;
   logic [7:0] rst_stat_ff;
   logic srst_ff;
   logic [PULLUP_W-1:0] pullup_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic [FW_W+UID_W-1:0] id_src;
   logic wr_cmd;
   logic wr_ack;
   logic start;
   logic known;
   imc_prot_t prot;
   logic busy;
   logic exec_done;
   logic [N_CMD-1:0] stb;
   logic int_en;
   logic do_copy;

   // refuse settings the register map cannot serve
   if (N_PARAM * 8 != 64 || EXEC_LEN < 1) begin : g_bad_cfg
      $error("unsupported parameter setting");
   end

   // ==================================================
   // register port decode
   // command register write
   assign wr_cmd = REG_REQ_I.wr && REG_REQ_I.addr == OFS_CMD;
   assign wr_ack = wr_cmd && REG_REQ_I.wdata == CODE_ACK;
   // new codes only when idle and acknowledged
   assign start = wr_cmd && !wr_ack && !busy && !done_ff && !srst_ff;
   assign int_en = sens_ctrl_ff[INT_EN_BIT] && !feat_ctrl_ff[INT_DIS_BIT];
   assign do_copy = copy_pend_ff || stb[CMD_COPY_ID];
   assign id_src = {UID_I, FW_VER_I};

   imc_cmd_exec #(
      .EXEC_LEN(EXEC_LEN)
   ) u_exec (
      .clk_i(SYS_CLK_I),
      .rst_n_i(NRST_I),
      .srst_i(srst_ff),
      .start_i(start),
      .code_i(REG_REQ_I.wdata),
      .known_o(known),
      .prot_o(prot),
      .busy_o(busy),
      .done_o(exec_done),
      .stb_o(stb)
   );

   // ==================================================
   // command register readback
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cmd_ff <= CODE_ACK;
      end else if (srst_ff) begin
         cmd_ff <= CODE_ACK;
      end else if (wr_ack || (start && known)) begin
         cmd_ff <= REG_REQ_I.wdata;
      end
   end

   // ==================================================
   // completion flag: a finish in the acknowledge cycle wins
   // set on finish, clear on acknowledge
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         done_ff <= 1'b0;
      end else if (srst_ff) begin
         done_ff <= 1'b0;
      end else if (exec_done) begin
         done_ff <= 1'b1;
      end else if (wr_ack) begin
         done_ff <= 1'b0;
      end
   end

   // interrupt line follows the flag while enabled
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         int_ff <= 1'b0;
      end else begin
         int_ff <= done_ff && int_en && !srst_ff;
      end
   end

   // ==================================================
   // interrupt enable controls
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sens_ctrl_ff <= CTRL_RST_VAL;
         feat_ctrl_ff <= CTRL_RST_VAL;
      end else if (srst_ff) begin
         sens_ctrl_ff <= CTRL_RST_VAL;
         feat_ctrl_ff <= CTRL_RST_VAL;
      end else if (REG_REQ_I.wr) begin
         if (REG_REQ_I.addr == OFS_SENS_CTRL) begin
            sens_ctrl_ff <= REG_REQ_I.wdata;
         end
         if (REG_REQ_I.addr == OFS_FEAT_CTRL) begin
            feat_ctrl_ff <= REG_REQ_I.wdata;
         end
      end
   end

   // ==================================================
   // parameter registers, frozen while a function runs
   // eight bytes at consecutive offsets
   for (genvar i = 0; i < N_PARAM; i++) begin : g_param
      always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
         if (!NRST_I) begin
            param_ff[i] <= CTRL_RST_VAL;
         end else if (srst_ff) begin
            param_ff[i] <= CTRL_RST_VAL;
         end else if (REG_REQ_I.wr && !busy &&
                      REG_REQ_I.addr == OFS_PARAM0 + 7'(i)) begin
            param_ff[i] <= REG_REQ_I.wdata;
         end
      end
      assign PARAM_O[8*i +: 8] = param_ff[i];
   end

   // ==================================================
   // identity copy: once after reset and on request
   // version and serial copied to host registers
   for (genvar i = 0; i < N_ID; i++) begin : g_id
      always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
         if (!NRST_I) begin
            id_ff[i] <= CTRL_RST_VAL;
         end else if (do_copy) begin
            id_ff[i] <= id_src[8*i +: 8];
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         copy_pend_ff <= 1'b1;
      end else begin
         copy_pend_ff <= srst_ff;
      end
   end

   // ==================================================
   // pull-up disable bits taken from the first parameter byte
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pullup_ff <= '0;
      end else if (srst_ff) begin
         pullup_ff <= '0;
      end else if (stb[CMD_PULLUP]) begin
         pullup_ff <= param_ff[0][PULLUP_W-1:0];
      end
   end

   // ==================================================
   // tap result, reserved bits zero
   // direction, axis, count; count 3 dropped
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tap_ff <= CTRL_RST_VAL;
      end else if (srst_ff) begin
         tap_ff <= CTRL_RST_VAL;
      end else if (TAP_EVT_I.valid && TAP_EVT_I.count != TAP_NUM_BAD) begin
         tap_ff <= CTRL_RST_VAL;
         tap_ff[TAP_DIR_BIT] <= TAP_EVT_I.negative;
         tap_ff[TAP_AXIS_LSB +: 2] <= TAP_EVT_I.axis;
         tap_ff[TAP_NUM_LSB +: 2] <= TAP_EVT_I.count;
      end
   end

   // ==================================================
   // step counter
   // 24-bit count, cleared by reset
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         step_ff <= STEP_RST_VAL;
      end else if (srst_ff || stb[CMD_STEP_RST]) begin
         step_ff <= STEP_RST_VAL;
      end else if (STEP_INC_I) begin
         step_ff <= step_ff + 24'h000001;
      end
   end

   // ==================================================
   // soft reset trigger and reset status
   // magic value starts reset in any mode
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         srst_ff <= 1'b0;
      end else begin
         srst_ff <= REG_REQ_I.wr && REG_REQ_I.addr == OFS_SOFT_RST &&
                    REG_REQ_I.wdata == RST_MAGIC;
      end
   end

   // reads the done value after any reset
   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_stat_ff <= RST_DONE_VAL;
      end else if (srst_ff) begin
         rst_stat_ff <= RST_DONE_VAL;
      end else if (REG_REQ_I.wr && REG_REQ_I.addr == OFS_SOFT_RST &&
                   REG_REQ_I.wdata == RST_MAGIC) begin
         rst_stat_ff <= CTRL_RST_VAL;
      end
   end

   // ==================================================
   // read mux, answered one cycle after the read
   // every register on the one port except the soft reset trigger, which reads zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (REG_REQ_I.addr >= OFS_PARAM0 &&
          REG_REQ_I.addr < OFS_PARAM0 + 7'(N_PARAM)) begin
         nxt_rdata = param_ff[3'(REG_REQ_I.addr - OFS_PARAM0)];
      end else if (REG_REQ_I.addr >= OFS_ID0 &&
                   REG_REQ_I.addr < OFS_ID0 + 7'(N_ID)) begin
         nxt_rdata = id_ff[4'(REG_REQ_I.addr - OFS_ID0)];
      end else begin
         unique case (REG_REQ_I.addr)
            OFS_CMD: nxt_rdata = cmd_ff;
            OFS_STATUS: nxt_rdata[DONE_BIT] = done_ff;
            OFS_SENS_CTRL: nxt_rdata = sens_ctrl_ff;
            OFS_FEAT_CTRL: nxt_rdata = feat_ctrl_ff;
            OFS_RST_STAT: nxt_rdata = rst_stat_ff;
            OFS_TAP: nxt_rdata = tap_ff;
            OFS_STEP_LOW: nxt_rdata = step_ff[7:0];
            OFS_STEP_MID: nxt_rdata = step_ff[15:8];
            OFS_STEP_HIGH: nxt_rdata = step_ff[23:16];
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdata_ff <= 8'h00;
      end else if (REG_REQ_I.rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ==================================================
   // outputs
   // FIFO reset pulse clears data, count and flags
   assign FIFO_RST_O = stb[CMD_FIFO_RST];
   assign CMD_STB_O = stb;
   assign REG_RDATA_O = rdata_ff;
   assign FIRST_IRQ_PIN_O = int_ff;
   assign PULLUP_DIS_O = pullup_ff;
   assign SOFT_RST_O = srst_ff;

   // ==================================================
   // checks
   // finish raises flag
   done_set_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      exec_done && !srst_ff |=> done_ff ##1 (int_ff == int_en))
      else $error("finish did not raise completion flag");

   ack_clear_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      wr_ack && done_ff && !exec_done |=> !done_ff ##1 !int_ff)
      else $error("acknowledge did not clear completion");

   // known code runs for the full length then strobes
   dispatch_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I || srst_ff)
      start && known |=> busy [*1] ##(EXEC_LEN) exec_done)
      else $error("known code not executed on time");

   unknown_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      start && !known |=> !busy && $stable(done_ff) && $stable(cmd_ff))
      else $error("unknown code changed state");

   fifo_type_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      wr_cmd && REG_REQ_I.wdata == CODE_FIFO_REQ |-> prot == PROT_READ)
      else $error("FIFO request not read type");

   plain_type_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      wr_cmd && REG_REQ_I.wdata == CODE_FIFO_RST |-> prot == PROT_PLAIN)
      else $error("FIFO reset not plain type");

   ofs_type_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      wr_cmd && REG_REQ_I.wdata == CODE_GYR_OFS |-> prot == PROT_WRITE)
      else $error("offset code not write type");

   step_clr_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      stb[CMD_STEP_RST] |=> step_ff == STEP_RST_VAL)
      else $error("step count not cleared");

   tap_num_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      tap_ff[TAP_NUM_LSB +: 2] != TAP_NUM_BAD)
      else $error("tap count holds unused value");

   // magic write resets and reports success
   soft_rst_a: assert property (
      @(posedge SYS_CLK_I) disable iff (!NRST_I)
      REG_REQ_I.wr && REG_REQ_I.addr == OFS_SOFT_RST &&
      REG_REQ_I.wdata == RST_MAGIC
      |=> srst_ff ##1 (rst_stat_ff == RST_DONE_VAL && !done_ff))
      else $error("soft reset sequence wrong");
endmodule

//--- bench/imc_host_model.sv
// host processor model driving the register port
`timescale 1ns/1ps
module imc_host_model import imc_pkg::*; (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output imc_reg_req_t req_o
);
   initial req_o = '0;
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i) req_o <= '{1'b1, 1'b0, a, d};
      // released lines show the inverse
      @(posedge clk_i) req_o <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // read, data taken once the answer has landed
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_i) req_o <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_i) req_o <= '{1'b0, 1'b0, ~a, 8'hff};
      #1 d = rdata_i;
   endtask
   task automatic cmd(input logic [7:0] c, output logic ok);
      logic [7:0] s;
      ok = 1'b0;
      wr(OFS_CMD, c);
      for (int i = 0; i < 40 && !ok; i++) begin
         rd(OFS_STATUS, s);
         ok = s[DONE_BIT];
      end
      wr(OFS_CMD, CODE_ACK);
   endtask
endmodule

//--- bench/imc_host_cmd_tb_top.sv
// self-checking testbench of the host command block
`timescale 1ns/1ps
module imc_host_cmd_tb_top import imc_pkg::*; ;
   logic clk, nrst, step, first_irq_pin, frst, srst, ok, fseen, sseen;
   imc_reg_req_t req;
   imc_tap_t tap;
   logic [7:0] rdat, v;
   logic [47:0] uid;
   logic [23:0] fw;
   logic [N_CMD-1:0] stb, seen;
   logic [63:0] prm, e;
   logic [3:0] pu;
   int n_mismatch, tests_run;
   // ==================================================
   // design, host and clock
   imc_host_cmd DUT (.SYS_CLK_I(clk), .NRST_I(nrst), .REG_REQ_I(req),
      .TAP_EVT_I(tap), .STEP_INC_I(step), .UID_I(uid), .FW_VER_I(fw),
      .REG_RDATA_O(rdat), .FIRST_IRQ_PIN_O(first_irq_pin), .CMD_STB_O(stb),
      .PARAM_O(prm), .PULLUP_DIS_O(pu), .FIFO_RST_O(frst),
      .SOFT_RST_O(srst));
   imc_host_model host (.clk_i(clk), .rdata_i(rdat), .req_o(req));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // collects strobes between clears
   always @(posedge clk) begin
      seen <= seen | stb;
      fseen <= fseen | frst;
      sseen <= sseen | srst;
   end
   task automatic clr;
      #1 seen = '0;
      fseen = 1'b0;
      sseen = 1'b0;
   endtask
   task automatic chk(string nm, logic [63:0] x, logic [63:0] g);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic rchk(string nm, logic [6:0] a, logic [7:0] x);
      host.rd(a, v);
      chk(nm, x, v);
   endtask
   // ==================================================
   // scenarios
   task automatic t_reset;
      rchk("reset status", OFS_RST_STAT, RST_DONE_VAL);
      rchk("tap idle", OFS_TAP, 8'h00);
      for (int i = 0; i < 3; i++)
         rchk("steps", OFS_STEP_LOW + 7'(i), 8'h00);
      $display("test reset ends");
   endtask
   task automatic t_params;
      for (int i = 0; i < 8; i++) begin
         e[8*i+:8] = 8'h11 * 8'(i + 1);
         host.wr(OFS_PARAM0 + 7'(i), e[8*i+:8]);
      end
      for (int i = 0; i < 8; i++)
         rchk("param", OFS_PARAM0 + 7'(i), e[8*i+:8]);
      chk("param out", e, prm);
      $display("test params ends");
   endtask
   task automatic t_codes;
      logic [7:0] c[14] = '{CODE_FIFO_RST, CODE_FIFO_REQ, CODE_WOM,
         CODE_ACC_OFS, CODE_GYR_OFS, CODE_TAP_CFG, CODE_PED_CFG,
         CODE_MOT_CFG, CODE_STEP_RST, CODE_COPY_ID, CODE_PULLUP,
         CODE_CLK_GATE, CODE_GYR_CAL, CODE_GAIN_RST};
      @(posedge clk) uid <= 48'h665544332211;
      for (int i = 0; i < 14; i++) begin
         clr();
         host.cmd(c[i], ok);
         chk("done", 1'b1, ok);
         chk("strobe", 64'(1) << i, seen);
         chk("fifo reset", i == 0, fseen);
         rchk("ack", OFS_STATUS, 8'h00);
      end
      chk("pullup", 4'h1, pu);
      chk("params kept", e, prm);
      rchk("fw byte", OFS_ID0, fw[7:0]);
      rchk("id byte", OFS_ID0 + 7'h3, 8'h11);
      $display("test codes ends");
   endtask
   task automatic t_irq;
      host.wr(OFS_SENS_CTRL, 8'h08);
      host.wr(OFS_FEAT_CTRL, 8'h00);
      host.wr(OFS_CMD, CODE_TAP_CFG);
      repeat (10) @(posedge clk);
      #1 chk("irq up", 1'b1, first_irq_pin);
      host.wr(OFS_CMD, CODE_ACK);
      repeat (2) @(posedge clk);
      #1 chk("irq down", 1'b0, first_irq_pin);
      host.wr(OFS_FEAT_CTRL, 8'h80);
      host.wr(OFS_CMD, CODE_PED_CFG);
      repeat (12) @(posedge clk);
      #1 chk("irq masked", 1'b0, first_irq_pin);
      host.wr(OFS_CMD, CODE_ACK);
      clr();
      host.wr(OFS_CMD, 8'h01);
      repeat (12) @(posedge clk);
      rchk("unknown flag", OFS_STATUS, 8'h00);
      chk("unknown strobe", '0, seen);
      rchk("unknown cmd", OFS_CMD, CODE_ACK);
      $display("test irq ends");
   endtask
   task automatic t_tap_step;
      @(posedge clk) tap <= '{1'b1, 1'b1, 2'h3, 2'h2};
      @(posedge clk) tap <= '{1'b1, 1'b0, 2'h1, 2'h3};
      @(posedge clk) tap <= '0;
      rchk("tap neg z", OFS_TAP, 8'hb2);
      @(posedge clk) tap <= '{1'b1, 1'b0, 2'h1, 2'h1};
      @(posedge clk) tap <= '0;
      rchk("tap pos x", OFS_TAP, 8'h11);
      @(posedge clk) step <= 1'b1;
      repeat (3) @(posedge clk);
      step <= 1'b0;
      rchk("steps low", OFS_STEP_LOW, 8'h03);
      $display("test tap ends");
   endtask
   task automatic t_soft;
      clr();
      host.wr(OFS_SOFT_RST, RST_MAGIC);
      repeat (2) @(posedge clk);
      chk("soft pulse", 1'b1, sseen);
      rchk("after soft", OFS_RST_STAT, RST_DONE_VAL);
      chk("params clr", '0, prm);
      rchk("steps clr", OFS_STEP_LOW, 8'h00);
      $display("test soft ends");
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==================================================
   // main sequence and watchdog
   initial begin
      nrst = 1'b0;
      tap = '0;
      step = 1'b0;
      uid = 48'h0c0b0a090807; // arbitrary serial value
      fw = 24'h030201; // arbitrary version value
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_params();
      t_codes();
      t_irq();
      t_tap_step();
      t_soft();
      tally_and_finish();
   end
   initial begin
      #2000000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
